// ===== rtl/flow_vlan_pkg.sv
// shared constants for the flow-control and vlan-detect block
package flow_vlan_pkg;
    // register indices; byte address is four times the index
    localparam logic [3:0] IDX_FLOW     = 4'h8;
    localparam logic [3:0] IDX_VLAN_ONE = 4'h9;
    localparam logic [3:0] IDX_VLAN_TWO = 4'ha;
    localparam logic [3:0] IDX_CTRL     = 4'hd;
    localparam logic [3:0] IDX_STAT     = 4'he;
    // flow register fields
    localparam int FLOW_PT_LSB   = 16;
    localparam int FLOW_PASS_BIT = 2;
    localparam int FLOW_EN_BIT   = 1;
    localparam int FLOW_BUSY_BIT = 0;
    // control register fields
    localparam int CTRL_FDX_BIT   = 0;
    localparam int CTRL_TXEN_BIT  = 1;
    localparam int CTRL_PROM_BIT  = 2;
    localparam int CTRL_SEND_BIT  = 3;
    localparam logic [31:0] RESET_VALUE = 32'h0000_0000;
    // frame layout, zero-based byte positions
    localparam int TYPE_HI_POS  = 12;
    localparam int TYPE_LO_POS  = 13;
    localparam int OPC_HI_POS   = 14;
    localparam int OPC_LO_POS   = 15;
    localparam int PT_HI_POS    = 16;
    localparam int PT_LO_POS    = 17;
    localparam int DA_LEN       = 6;
    localparam int SA_LEN       = 6;
    localparam int MAX_LEN      = 1518;
    localparam int MAX_LEN_VLAN = 1522;
    localparam int PAUSE_BYTES  = 60;
    localparam logic [15:0] CTRL_TYPE    = 16'h8808;
    localparam logic [15:0] PAUSE_OPCODE = 16'h0001;
    localparam logic [47:0] PAUSE_DA     = 48'h0180_c200_0001;
    // slot time is 512 bit times, 5120 ns at 100 Mb/s
    localparam int CLK_PERIOD_NS = 10;
    localparam int SLOT_TIME_NS  = 5120;
    localparam int SLOT_CYCLES   = SLOT_TIME_NS / CLK_PERIOD_NS;
endpackage

// ===== rtl/pause_frame_gen.sv
// byte sequencer for an outgoing pause control frame
`timescale 1ns/1ns
module pause_frame_gen #(
    parameter logic [47:0] STATION_ADDR = 48'h0200_0000_0001
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        start,
    input  wire logic [15:0] pause_time,
    output logic             valid,
    output logic [7:0]       data,
    input  wire logic        ready,
    output logic             active
);
    localparam int CW = 6;
    logic [CW-1:0] idx_reg;
    logic [CW-1:0] idx_next;
    logic          act_reg;
    logic [15:0]   pt_reg;
    logic [7:0]    byte_reg;

    function automatic logic [7:0] frame_byte(input logic [CW-1:0] i, input logic [15:0] pt);
        int k;
        k = int'(i);
        if (k < flow_vlan_pkg::DA_LEN)
            frame_byte = flow_vlan_pkg::PAUSE_DA[8'(47 - 8 * k) -: 8];
        else if (k < flow_vlan_pkg::DA_LEN + flow_vlan_pkg::SA_LEN)
            frame_byte = STATION_ADDR[8'(95 - 8 * k) -: 8];
        else if (k == flow_vlan_pkg::TYPE_HI_POS)
            frame_byte = flow_vlan_pkg::CTRL_TYPE[15:8];
        else if (k == flow_vlan_pkg::TYPE_LO_POS)
            frame_byte = flow_vlan_pkg::CTRL_TYPE[7:0];
        else if (k == flow_vlan_pkg::OPC_HI_POS)
            frame_byte = flow_vlan_pkg::PAUSE_OPCODE[15:8];
        else if (k == flow_vlan_pkg::OPC_LO_POS)
            frame_byte = flow_vlan_pkg::PAUSE_OPCODE[7:0];
        else if (k == flow_vlan_pkg::PT_HI_POS)
            frame_byte = pt[15:8];
        else if (k == flow_vlan_pkg::PT_LO_POS)
            frame_byte = pt[7:0];
        else
            frame_byte = 8'h00;
    endfunction

    wire last_byte = idx_reg == CW'(flow_vlan_pkg::PAUSE_BYTES - 1);
    wire step      = act_reg && ready;
    assign idx_next = step ? (last_byte ? '0 : idx_reg + CW'(1)) : idx_reg;
    assign valid  = act_reg;
    assign data   = byte_reg;
    assign active = act_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            idx_reg  <= '0;
            act_reg  <= 1'b0;
            pt_reg   <= 16'h0000;
            byte_reg <= 8'h00;
        end else begin
            idx_reg <= idx_next;
            if (start && !act_reg) begin
                act_reg  <= 1'b1;
                pt_reg   <= pause_time;
                byte_reg <= frame_byte('0, pause_time);
            end else if (step) begin
                act_reg  <= !last_byte;
                byte_reg <= frame_byte(idx_next, pt_reg);
            end
        end
    end
endmodule

// ===== rtl/rx_frame_inspect.sv
// parses incoming frames for pause commands, vlan tags and length
`timescale 1ns/1ns
module rx_frame_inspect (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_data,
    input  wire logic        rx_end,
    input  wire logic        decode_en,
    input  wire logic [15:0] tag_one,
    input  wire logic [15:0] tag_two,
    output logic             done,
    output logic             is_pause,
    output logic [15:0]      pause_quanta,
    output logic             is_vlan,
    output logic             too_long
);
    logic [10:0] cnt_reg;
    logic [47:0] da_reg;
    logic [15:0] type_reg;
    logic [15:0] opc_reg;
    logic [15:0] pt_reg;
    logic        long_reg;

    wire [10:0] cnt_next = (cnt_reg == 11'h7ff) ? cnt_reg : cnt_reg + 11'h001;
    wire vlan_hit  = (type_reg == tag_one) || (type_reg == tag_two);
    wire [10:0] limit = vlan_hit ? 11'(flow_vlan_pkg::MAX_LEN_VLAN) : 11'(flow_vlan_pkg::MAX_LEN);
    wire pause_hit = decode_en && da_reg == flow_vlan_pkg::PAUSE_DA &&
                     type_reg == flow_vlan_pkg::CTRL_TYPE && opc_reg == flow_vlan_pkg::PAUSE_OPCODE;

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_reg <= '0; da_reg <= '0; type_reg <= '0; opc_reg <= '0; pt_reg <= '0;
            long_reg <= 1'b0; done <= 1'b0; is_pause <= 1'b0; pause_quanta <= '0;
            is_vlan <= 1'b0; too_long <= 1'b0;
        end else begin
            done <= rx_end;
            if (rx_valid) begin
                cnt_reg <= cnt_next;
                if (cnt_reg < 11'(flow_vlan_pkg::DA_LEN))
                    da_reg <= {da_reg[39:0], rx_data};
                if (cnt_reg == 11'(flow_vlan_pkg::TYPE_HI_POS) || cnt_reg == 11'(flow_vlan_pkg::TYPE_LO_POS))
                    type_reg <= {type_reg[7:0], rx_data};
                if (cnt_reg == 11'(flow_vlan_pkg::OPC_HI_POS) || cnt_reg == 11'(flow_vlan_pkg::OPC_LO_POS))
                    opc_reg <= {opc_reg[7:0], rx_data};
                if (cnt_reg == 11'(flow_vlan_pkg::PT_HI_POS) || cnt_reg == 11'(flow_vlan_pkg::PT_LO_POS))
                    pt_reg <= {pt_reg[7:0], rx_data};
                if (cnt_reg >= limit)
                    long_reg <= 1'b1;
            end
            if (rx_end) begin
                is_pause     <= pause_hit;
                pause_quanta <= pt_reg;
                is_vlan      <= vlan_hit;
                too_long     <= long_reg || (rx_valid && cnt_reg >= limit);
                cnt_reg <= '0; da_reg <= '0; type_reg <= '0; opc_reg <= '0; long_reg <= 1'b0;
            end
        end
    end
endmodule

// ===== rtl/mac_flow_control_vlan_detect.sv
// top of the flow-control and vlan-detect block with its wishbone slave
//
// Local design decision: the Wishbone register port.
`timescale 1ns/1ns
module mac_flow_control_vlan_detect #(
    parameter logic [47:0] STATION_ADDR = 48'h0200_0000_0001, // arbitrary source address
    parameter int          SLOT_CYCLES  = flow_vlan_pkg::SLOT_CYCLES
) (
    input  wire logic        CLK,
    input  wire logic        SYS_RST,
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [5:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic [31:0]      WB_DAT_O,
    output logic             WB_ACK_O,
    input  wire logic        RX_VALID,
    input  wire logic [7:0]  RX_DATA,
    input  wire logic        RX_END,
    input  wire logic        RX_GOOD,
    input  wire logic        RX_ADDR_PASS,
    input  wire logic        RX_CONGESTED,
    output logic             RX_FWD_VALID,
    output logic [7:0]       RX_FWD_DATA,
    output logic             RX_STAT_VALID,
    output logic             RX_STAT_FILTER,
    output logic             RX_STAT_GOOD,
    output logic             RX_STAT_VLAN,
    output logic             RX_STAT_TOO_LONG,
    output logic             RX_STAT_CONTROL,
    output logic             TX_HOLD,
    output logic             TX_PAUSE_VALID,
    output logic [7:0]       TX_PAUSE_DATA,
    input  wire logic        TX_PAUSE_READY,
    output logic             BACKPRESSURE
);
    initial begin
        if (SLOT_CYCLES < 1 || SLOT_CYCLES > 65535)
            $error("slot cycle count out of range");
    end

    logic [31:0] flow_reg;
    logic [31:0] vlan_one_reg;
    logic [31:0] vlan_two_reg;
    logic [2:0]  ctrl_reg;
    logic        send_reg;
    logic        ack_reg;
    logic [31:0] rdata_reg;
    logic [15:0] quanta_reg;
    logic [15:0] slot_reg;
    logic        bp_reg;
    logic        last_pause_reg;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
        for (int b = 0; b < 4; b++)
            merge[8*b +: 8] = sel[b] ? nw[8*b +: 8] : old[8*b +: 8];
    endfunction

    // bus decode; byte address bits 1:0 are ignored
    wire       req       = WB_CYC_I && WB_STB_I;
    wire [3:0] idx       = WB_ADR_I[5:2];
    wire       wr        = req && WB_WE_I && !ack_reg;
    wire       wr_flow   = wr && idx == flow_vlan_pkg::IDX_FLOW;
    wire       wr_v1     = wr && idx == flow_vlan_pkg::IDX_VLAN_ONE;
    wire       wr_v2     = wr && idx == flow_vlan_pkg::IDX_VLAN_TWO;
    wire       wr_ctrl   = wr && idx == flow_vlan_pkg::IDX_CTRL;

    wire        full_duplex = ctrl_reg[flow_vlan_pkg::CTRL_FDX_BIT];
    wire        tx_enable   = ctrl_reg[flow_vlan_pkg::CTRL_TXEN_BIT];
    wire        promiscuous = ctrl_reg[flow_vlan_pkg::CTRL_PROM_BIT];
    wire        fc_enable   = flow_reg[flow_vlan_pkg::FLOW_EN_BIT];
    wire        pass_ctrl   = flow_reg[flow_vlan_pkg::FLOW_PASS_BIT];
    wire [15:0] pause_time_value = flow_reg[flow_vlan_pkg::FLOW_PT_LSB +: 16];

    // receive side
    wire        insp_done;
    wire        insp_pause;
    wire [15:0] insp_quanta;
    wire        insp_vlan;
    wire        insp_long;
    logic       stat_good_reg;

    rx_frame_inspect u_inspect (
        .clk          (CLK),
        .rst          (SYS_RST),
        .rx_valid     (RX_VALID),
        .rx_data      (RX_DATA),
        .rx_end       (RX_END),
        .decode_en    (fc_enable),
        .tag_one      (vlan_one_reg[15:0]),
        .tag_two      (vlan_two_reg[15:0]),
        .done         (insp_done),
        .is_pause     (insp_pause),
        .pause_quanta (insp_quanta),
        .is_vlan      (insp_vlan),
        .too_long     (insp_long)
    );

    wire valid_pause = insp_pause && stat_good_reg && !insp_long;
    wire act_pause   = insp_done && valid_pause && full_duplex && fc_enable;
    // promiscuous mode wins over the control-frame pass bit, which wins over the address-pass result
    wire filter_bit  = promiscuous ? 1'b1 :
                       valid_pause ? pass_ctrl :
                       last_pause_reg;

    // transmit side
    wire gen_active;
    wire gen_start = send_reg && tx_enable && full_duplex;

    pause_frame_gen #(
        .STATION_ADDR (STATION_ADDR)
    ) u_gen (
        .clk        (CLK),
        .rst        (SYS_RST),
        .start      (gen_start),
        .pause_time (pause_time_value),
        .valid      (TX_PAUSE_VALID),
        .data       (TX_PAUSE_DATA),
        .ready      (TX_PAUSE_READY),
        .active     (gen_active)
    );

    wire bp_next = !full_duplex && fc_enable && tx_enable && RX_CONGESTED;
    wire busy    = gen_active || bp_reg;
    wire paused  = quanta_reg != 16'h0000;
    wire slot_end = slot_reg == 16'(SLOT_CYCLES - 1);

    wire [31:0] flow_view = {flow_reg[31:1], busy};
    wire [31:0] stat_view = {quanta_reg, 13'h0000, bp_reg, gen_active, paused};
    wire [31:0] rd_mux =
        idx == flow_vlan_pkg::IDX_FLOW     ? flow_view :
        idx == flow_vlan_pkg::IDX_VLAN_ONE ? {16'h0000, vlan_one_reg[15:0]} :
        idx == flow_vlan_pkg::IDX_VLAN_TWO ? {16'h0000, vlan_two_reg[15:0]} :
        idx == flow_vlan_pkg::IDX_CTRL     ? {29'h0000_0000, ctrl_reg} :
        idx == flow_vlan_pkg::IDX_STAT     ? stat_view : 32'h0000_0000;

    assign WB_ACK_O     = ack_reg;
    assign WB_DAT_O     = rdata_reg;
    assign TX_HOLD      = paused;
    assign BACKPRESSURE = bp_reg;
    assign RX_STAT_VALID = insp_done;
    assign RX_STAT_FILTER = filter_bit;

    // wishbone slave, one wait state, unmapped reads return zero
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            ack_reg   <= 1'b0;
            rdata_reg <= flow_vlan_pkg::RESET_VALUE;
        end else begin
            ack_reg   <= req && !ack_reg;
            rdata_reg <= (req && !ack_reg) ? rd_mux : rdata_reg;
        end
    end

    // register file; busy bit has no storage so a written one is dropped
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            flow_reg     <= flow_vlan_pkg::RESET_VALUE;
            vlan_one_reg <= flow_vlan_pkg::RESET_VALUE;
            vlan_two_reg <= flow_vlan_pkg::RESET_VALUE;
            ctrl_reg     <= 3'h0;
        end else begin
            if (wr_flow)
                flow_reg <= merge(flow_reg, WB_DAT_I, WB_SEL_I) & 32'hffff_0006;
            if (wr_v1)
                vlan_one_reg <= merge(vlan_one_reg, WB_DAT_I, WB_SEL_I) & 32'h0000_ffff;
            if (wr_v2)
                vlan_two_reg <= merge(vlan_two_reg, WB_DAT_I, WB_SEL_I) & 32'h0000_ffff;
            if (wr_ctrl && WB_SEL_I[0])
                ctrl_reg <= WB_DAT_I[2:0];
        end
    end

    // send request waits until the generator takes it, tx is turned off or full duplex is cleared
    always_ff @(posedge CLK) begin
        if (SYS_RST)
            send_reg <= 1'b0;
        else if (wr_ctrl && WB_SEL_I[0] && WB_DAT_I[flow_vlan_pkg::CTRL_SEND_BIT])
            send_reg <= 1'b1;
        else if ((gen_start && !gen_active) || !tx_enable || !full_duplex)
            send_reg <= 1'b0;
    end

    // pause timer: quanta count down once per slot time
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            quanta_reg <= 16'h0000;
            slot_reg   <= 16'h0000;
        end else if (act_pause) begin
            quanta_reg <= insp_quanta;
            slot_reg   <= 16'h0000;
        end else if (!fc_enable || !full_duplex) begin
            quanta_reg <= 16'h0000;
            slot_reg   <= 16'h0000;
        end else if (paused) begin
            slot_reg   <= slot_end ? 16'h0000 : slot_reg + 16'h0001;
            quanta_reg <= slot_end ? quanta_reg - 16'h0001 : quanta_reg;
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            bp_reg         <= 1'b0;
            stat_good_reg  <= 1'b0;
            last_pause_reg <= 1'b0;
        end else begin
            bp_reg <= bp_next;
            if (RX_END)
                stat_good_reg <= RX_GOOD;
            last_pause_reg <= RX_ADDR_PASS;
        end
    end

    // every byte and every status word goes out, good or bad
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            RX_FWD_VALID     <= 1'b0;
            RX_FWD_DATA      <= 8'h00;
            RX_STAT_GOOD     <= 1'b0;
            RX_STAT_VLAN     <= 1'b0;
            RX_STAT_TOO_LONG <= 1'b0;
            RX_STAT_CONTROL  <= 1'b0;
        end else begin
            RX_FWD_VALID <= RX_VALID;
            RX_FWD_DATA  <= RX_VALID ? RX_DATA : RX_FWD_DATA;
            if (RX_END) begin
                RX_STAT_GOOD <= RX_GOOD;
            end
            RX_STAT_VLAN     <= insp_vlan;
            RX_STAT_TOO_LONG <= insp_long;
            RX_STAT_CONTROL  <= insp_pause;
        end
    end
endmodule

// ===== test/mac_flow_control_vlan_detect_assertions.sv
// concurrent checks on the flow-control and vlan-detect block ports
`timescale 1ns/1ns
module flow_vlan_checker #(
    parameter int SLOT_CYCLES = 4
) (
    input wire logic        CLK,
    input wire logic        SYS_RST,
    input wire logic        WB_CYC_I,
    input wire logic        WB_STB_I,
    input wire logic        WB_WE_I,
    input wire logic [5:0]  WB_ADR_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic        WB_ACK_O,
    input wire logic        RX_VALID,
    input wire logic [7:0]  RX_DATA,
    input wire logic        RX_END,
    input wire logic        RX_CONGESTED,
    input wire logic        RX_FWD_VALID,
    input wire logic [7:0]  RX_FWD_DATA,
    input wire logic        RX_STAT_VALID,
    input wire logic        RX_STAT_FILTER,
    input wire logic        TX_HOLD,
    input wire logic        TX_PAUSE_VALID,
    input wire logic [7:0]  TX_PAUSE_DATA,
    input wire logic        TX_PAUSE_READY,
    input wire logic        BACKPRESSURE
);
    logic [3:0] ctrl_reg;
    logic       flow_ctrl_enable_reg;
    wire        take    = WB_CYC_I && WB_STB_I && !WB_ACK_O && WB_WE_I;
    // shadow assumes the bench writes with all byte lanes enabled
    wire        fdx     = ctrl_reg[flow_vlan_pkg::CTRL_FDX_BIT];
    wire        txen    = ctrl_reg[flow_vlan_pkg::CTRL_TXEN_BIT];
    wire        prom    = ctrl_reg[flow_vlan_pkg::CTRL_PROM_BIT];
    wire        bp_cond = !fdx && flow_ctrl_enable_reg && txen && RX_CONGESTED;
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            ctrl_reg <= 4'h0;
            flow_ctrl_enable_reg <= 1'b0;
        end else if (take && WB_ADR_I[5:2] == flow_vlan_pkg::IDX_CTRL) begin
            ctrl_reg <= WB_DAT_I[3:0];
        end else if (take && WB_ADR_I[5:2] == flow_vlan_pkg::IDX_FLOW) begin
            flow_ctrl_enable_reg <= WB_DAT_I[flow_vlan_pkg::FLOW_EN_BIT];
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack longer than one cycle");
    ack_answer_a: assert property ((WB_CYC_I && WB_STB_I && !WB_ACK_O) |=> WB_ACK_O)
        else $error("request not acked next cycle");
    fwd_copy_a: assert property (RX_FWD_VALID == $past(RX_VALID) &&
        (!RX_FWD_VALID || RX_FWD_DATA == $past(RX_DATA))) else $error("forwarded byte differs");
    stat_timing_a: assert property (RX_STAT_VALID == $past(RX_END)) else $error("status not after end");
    filter_promisc_a: assert property ((RX_STAT_VALID && prom) |-> RX_STAT_FILTER)
        else $error("promiscuous did not set filter bit");
    backpressure_level_a: assert property (BACKPRESSURE == $past(bp_cond))
        else $error("back-pressure level wrong");
    hold_needs_enable_a: assert property ((!flow_ctrl_enable_reg && $past(!flow_ctrl_enable_reg) && $past(!flow_ctrl_enable_reg, 2))
        |-> !TX_HOLD) else $error("hold while flow control off");
    pause_start_a: assert property ($rose(TX_PAUSE_VALID) |-> (txen && fdx))
        else $error("pause frame started while not allowed");
    pause_stall_a: assert property ((TX_PAUSE_VALID && !TX_PAUSE_READY) |=>
        (TX_PAUSE_VALID && $stable(TX_PAUSE_DATA))) else $error("pause byte dropped during stall");
endmodule
bind mac_flow_control_vlan_detect flow_vlan_checker #(.SLOT_CYCLES(SLOT_CYCLES)) flow_vlan_checker_i (
    .CLK(CLK), .SYS_RST(SYS_RST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
    .WB_ADR_I(WB_ADR_I), .WB_DAT_I(WB_DAT_I), .WB_ACK_O(WB_ACK_O), .RX_VALID(RX_VALID), .RX_DATA(RX_DATA),
    .RX_END(RX_END), .RX_CONGESTED(RX_CONGESTED), .RX_FWD_VALID(RX_FWD_VALID), .RX_FWD_DATA(RX_FWD_DATA),
    .RX_STAT_VALID(RX_STAT_VALID), .RX_STAT_FILTER(RX_STAT_FILTER), .TX_HOLD(TX_HOLD),
    .TX_PAUSE_VALID(TX_PAUSE_VALID), .TX_PAUSE_DATA(TX_PAUSE_DATA), .TX_PAUSE_READY(TX_PAUSE_READY),
    .BACKPRESSURE(BACKPRESSURE));

// ===== test/link_partner_model.sv
// link partner model: sends frames to the receiver, takes pause bytes
`timescale 1ns/1ns
module link_partner_model (
    input  wire logic       clk,
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    output logic            rx_end,
    output logic            rx_good,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    output logic            tx_ready
);
    logic [7:0] tx_bytes [0:63];
    int         tx_count = 0;
    logic       slow     = 1'b0;
    initial begin
        rx_valid = 1'b0;
        rx_data  = 8'h00;
        rx_end   = 1'b0;
        rx_good  = 1'b0;
        tx_ready = 1'b0;
    end
    // slow mode stalls every other cycle so held bytes get exercised
    always @(posedge clk) tx_ready <= slow ? !tx_ready : 1'b1;
    // sampled mid-cycle, so each hit is one byte taken at the next edge
    always @(negedge clk) begin
        if (tx_valid === 1'b1 && tx_ready === 1'b1 && tx_count < 64) begin
            tx_bytes[tx_count] = tx_data;
            tx_count++;
        end
    end
    task send(input logic [15:0] typ, input logic [15:0] quanta, input int len, input logic good);
        logic [7:0] b;
        for (int i = 1; i <= len; i++) begin
            b = 8'(i);
            if (i <= 6) b = 8'(flow_vlan_pkg::PAUSE_DA >> (48 - 8 * i));
            if (i == 13) b = typ[15:8];
            if (i == 14) b = typ[7:0];
            if (i == 15) b = 8'h00;
            if (i == 16) b = 8'h01;
            if (i == 17) b = quanta[15:8];
            if (i == 18) b = quanta[7:0];
            @(posedge clk);
            rx_valid <= 1'b1;
            rx_data  <= b;
            rx_end   <= (i == len);
            rx_good  <= good;
        end
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_end   <= 1'b0;
        // released data line shows the inverse, not a stale byte
        rx_data  <= ~rx_data;
    endtask
endmodule

// ===== test/mac_flow_control_vlan_detect_bench.sv
// self-checking bench for the flow-control and vlan-detect block
`timescale 1ns/1ns
module mac_flow_control_vlan_detect_bench;
    logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, apass = 1'b0, cong = 1'b0;
    logic [5:0]  adr = 6'h00;
    logic [3:0]  sel = 4'hf;
    logic [31:0] dat = 32'h0, dat_o, q;
    logic        ack, rv, re, rg, sv, sf, sg, svl, stl, sc, hold, pv, pr, bp;
    logic [7:0]  rd, pd;
    int          bad_count = 0, compares = 0, cycles = 0, n;
    logic [15:0] vt [5] = '{16'h8100, 16'h8100, 16'h88a8, 16'h0800, 16'h0800};
    int          vl [5] = '{1522, 1523, 1522, 1519, 1518};
    logic [1:0]  ve [5] = '{2'b10, 2'b11, 2'b10, 2'b01, 2'b00};
    initial forever #5 clk = ~clk;
    mac_flow_control_vlan_detect #(.SLOT_CYCLES(4)) mac_flow_control_vlan_detect_i (
        .CLK(clk), .SYS_RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
        .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .RX_VALID(rv), .RX_DATA(rd),
        .RX_END(re), .RX_GOOD(rg), .RX_ADDR_PASS(apass), .RX_CONGESTED(cong), .RX_FWD_VALID(),
        .RX_FWD_DATA(), .RX_STAT_VALID(sv), .RX_STAT_FILTER(sf), .RX_STAT_GOOD(sg), .RX_STAT_VLAN(svl),
        .RX_STAT_TOO_LONG(stl), .RX_STAT_CONTROL(sc), .TX_HOLD(hold), .TX_PAUSE_VALID(pv),
        .TX_PAUSE_DATA(pd), .TX_PAUSE_READY(pr), .BACKPRESSURE(bp));
    link_partner_model link_partner_model_i (.clk(clk), .rx_valid(rv), .rx_data(rd), .rx_end(re),
        .rx_good(rg), .tx_valid(pv), .tx_data(pd), .tx_ready(pr));
    task tally_and_finish;
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wb(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        {cyc, stb, we, adr, dat} <= {1'b1, 1'b1, w, a, d};
        // request stands until the edge that samples ack high; data taken there
        do @(posedge clk); while (ack !== 1'b1);
        q = dat_o;
        {cyc, stb} <= 2'b00;
    endtask
    // exp is {control, filter, vlan, too_long, good}; hold is counted in cycles
    task rx(input logic [15:0] typ, input int len, input logic good, input logic [4:0] exp, input int hc);
        link_partner_model_i.send(typ, 16'h0002, len, good);
        n = 0;
        @(negedge clk);
        while (sv !== 1'b1 && n < 8) begin
            @(negedge clk);
            n++;
        end
        q[3] = sf;
        @(negedge clk);
        {q[4], q[2:0]} = {sc, svl, stl, sg};
        chk(32'(q[4:0]), 32'(exp));
        n = 0;
        repeat (40) begin
            if (hold === 1'b1) n++;
            @(negedge clk);
        end
        chk(32'(n), 32'(hc));
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            bad_count++;
            tally_and_finish;
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            wb(1'b0, 6'h20 + 6'(4 * i), 32'h0);
            chk(q, 32'h0);
        end
        wb(1'b1, 6'h24, 32'hffff_8100);
        wb(1'b1, 6'h28, 32'h0000_88a8);
        wb(1'b0, 6'h24, 32'h0);
        chk(q, 32'h0000_8100);
        wb(1'b0, 6'h28, 32'h0);
        chk(q, 32'h0000_88a8);
        sel <= 4'h2;
        wb(1'b1, 6'h28, 32'hffff_55ff);
        sel <= 4'hf;
        wb(1'b0, 6'h28, 32'h0);
        chk(q, 32'h0000_55a8);
        wb(1'b1, 6'h28, 32'h0000_88a8);
        wb(1'b1, 6'h20, 32'h0003_0006);
        wb(1'b0, 6'h20, 32'h0);
        chk(q, 32'h0003_0006);
        $display("test registers done");
        wb(1'b1, 6'h34, 32'h3);
        link_partner_model_i.slow <= 1'b1;
        wb(1'b1, 6'h34, 32'hb);
        wb(1'b0, 6'h20, 32'h0);
        chk(q & 32'h1, 32'h1);
        n = 0;
        while (pv !== 1'b0 && n < 400) begin
            @(negedge clk);
            n++;
        end
        wb(1'b0, 6'h20, 32'h0);
        chk(q, 32'h0003_0006);
        chk(32'(link_partner_model_i.tx_count), 32'd60);
        chk({link_partner_model_i.tx_bytes[16], link_partner_model_i.tx_bytes[17]}, 32'h0003);
        chk({link_partner_model_i.tx_bytes[12], link_partner_model_i.tx_bytes[13],
             link_partner_model_i.tx_bytes[14], link_partner_model_i.tx_bytes[15]}, 32'h8808_0001);
        $display("test pause send done");
        rx(16'h8808, 64, 1'b1, 5'b11001, 8);
        wb(1'b1, 6'h20, 32'h0003_0002);
        rx(16'h8808, 64, 1'b1, 5'b10001, 8);
        rx(16'h8808, 64, 1'b0, 5'b10000, 0);
        wb(1'b1, 6'h34, 32'h7);
        rx(16'h8808, 64, 1'b1, 5'b11001, 8);
        wb(1'b1, 6'h20, 32'h0003_0004);
        rx(16'h8808, 64, 1'b1, 5'b01001, 0);
        wb(1'b1, 6'h20, 32'h0003_0006);
        wb(1'b1, 6'h34, 32'h2);
        rx(16'h8808, 64, 1'b1, 5'b11001, 0);
        $display("test pause receive done");
        wb(1'b1, 6'h34, 32'h3);
        apass <= 1'b1;
        for (int i = 0; i < 5; i++) rx(vt[i], vl[i], 1'b1, {2'b01, ve[i], 1'b1}, 0);
        $display("test vlan done");
        wb(1'b1, 6'h34, 32'h2);
        cong <= 1'b1;
        repeat (3) @(negedge clk);
        chk(32'(bp), 32'h1);
        wb(1'b0, 6'h20, 32'h0);
        chk(q & 32'h1, 32'h1);
        wb(1'b1, 6'h34, 32'h0);
        repeat (3) @(negedge clk);
        chk(32'(bp), 32'h0);
        wb(1'b1, 6'h34, 32'h2);
        cong <= 1'b0;
        repeat (3) @(negedge clk);
        wb(1'b0, 6'h20, 32'h0);
        chk(q & 32'h1, 32'h0);
        wb(1'b1, 6'h34, 32'h9);
        repeat (8) @(negedge clk);
        chk(32'(pv), 32'h0);
        $display("test back-pressure done");
        tally_and_finish;
    end
endmodule
